// *** rtl/sdw_pkg.sv ***
package sdw_pkg;
    localparam logic [31:0] ADDR_CORE_RST = 32'h5005_01C0;
    localparam logic [31:0] ADDR_USER = 32'h5005_0200;
    localparam logic [31:0] ADDR_USER2 = 32'h5005_0204;
    localparam logic [31:0] ADDR_CLKDIV = 32'h5005_0208;
    localparam logic [31:0] ADDR_SDIO = 32'h5005_020C;
    localparam logic [31:0] ADDR_DMABUF = 32'h5005_0300;
    localparam int USER_SYNC_BIT = 15;
    localparam int USER_RDPEND_BIT = 14;
    localparam int USER_WRPEND_BIT = 13;
    localparam int USER_LOOP_BIT = 8;
    localparam int USER_GATE_BIT = 7;
    localparam int USER_ROUTE_LSB = 2;
    localparam int USER_CD_BIT = 0;
    localparam int USER2_ADJ_LSB = 8;
    localparam int USER2_SMODE_BIT = 0;
    localparam int SDIO_HOST_BIT = 0;
    localparam int SDIO_CARD_BIT = 1;
    localparam logic [2:0] ROUTE_BOTH_A = 3'h0;
    localparam logic [2:0] ROUTE_BOTH_B = 3'h1;
    localparam logic [2:0] ROUTE_NONE = 3'h2;
    localparam logic [2:0] ROUTE_RESET = 3'h1;
    localparam logic [1:0] CLKDIV_RESET = 2'h0;
    localparam logic CORE_RST_RESET = 1'b1;
    localparam logic [1:0] CORE_RST_FIXED = 2'h3;
    typedef struct packed {
        logic sync;
        logic loop;
        logic gate;
        logic [2:0] route;
        logic cd;
        logic [2:0] adj;
        logic smode;
        logic core_rst;
        logic [1:0] div;
        logic [15:0] dmabuf;
        logic [31:0] rdata;
        logic rx_req;
        logic tx_req;
        logic rd_stb;
        logic wr_stb;
        logic irq_clr;
    } sdw_regs_s;
endpackage

// *** rtl/sdw_clkdiv.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdw_clkdiv (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic en,
    input wire logic [1:0] div_sel,
    output logic card_clk
);
    typedef struct packed {
        logic [2:0] cnt;
        logic clk;
    } sdw_div_s;
    sdw_div_s st;
    sdw_div_s next_st;
    logic [2:0] half;

    always_comb begin
        // Half period in cycles minus one: 0, 1, 3, 7
        half = 3'((4'h1 << div_sel) - 4'h1);
        next_st = st;
        if (en) begin
            if (st.cnt >= half) begin
                next_st.cnt = 3'h0;
                next_st.clk = ~st.clk;
            end else begin
                next_st.cnt = st.cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign card_clk = st.clk;

    property p_div2;
        @(posedge pclk) disable iff (!presetn)
        (en && div_sel == 2'h0 && st.cnt == 3'h0) ##1 (en && div_sel == 2'h0)
            |=> card_clk != $past(card_clk);
    endproperty
    a_div2: assert property (p_div2) else $error("divide by 2 clock did not toggle");
endmodule
`default_nettype wire

// *** rtl/sdw_irq_det.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdw_irq_det (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic soft_rst,
    input wire logic dat1_pin,
    input wire logic bus_4bit,
    input wire logic data_busy,
    input wire logic sync_window,
    input wire logic clear,
    output logic host_irq,
    output logic card_irq
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic host;
        logic card;
    } sdw_irq_s;
    sdw_irq_s st;
    sdw_irq_s next_st;
    logic irq_low;
    logic sample_ok;

    always_comb begin
        irq_low = ~st.s2;
        // 1-bit bus: any period; 4-bit: idle line or the window between blocks
        sample_ok = !bus_4bit || !data_busy || sync_window;
        next_st = st;
        next_st.s1 = dat1_pin;
        next_st.s2 = st.s1;
        // Set wins over a clear in the same cycle
        if (soft_rst) begin
            next_st.host = 1'b0;
        end else if (irq_low && sample_ok) begin
            next_st.host = 1'b1;
        end else if (clear) begin
            next_st.host = 1'b0;
        end
        next_st.card = !soft_rst && irq_low && sample_ok && !sync_window;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.s1 <= 1'b1;
            st.s2 <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign host_irq = st.host;
    assign card_irq = st.card;

    property p_latch;
        @(posedge pclk) disable iff (!presetn)
        (host_irq && !clear && !soft_rst) |=> host_irq;
    endproperty
    a_latch: assert property (p_latch) else $error("host irq dropped without clear");
    property p_sync_only;
        @(posedge pclk) disable iff (!presetn)
        (sync_window && irq_low) |=> !card_irq;
    endproperty
    a_sync_only: assert property (p_sync_only) else $error("card irq in sync window");
    property p_busy4;
        @(posedge pclk) disable iff (!presetn)
        (bus_4bit && data_busy && !sync_window && !host_irq) |=> !host_irq;
    endproperty
    a_busy4: assert property (p_busy4) else $error("irq taken during 4-bit block");
    property p_1bit;
        @(posedge pclk) disable iff (!presetn)
        (!bus_4bit && irq_low && !soft_rst) |=> host_irq && card_irq == !$past(sync_window);
    endproperty
    a_1bit: assert property (p_1bit) else $error("1-bit irq not detected");
    c_sync_irq: cover property (@(posedge pclk) disable iff (!presetn)
        sync_window && bus_4bit && irq_low ##1 host_irq);
endmodule
`default_nettype wire

// *** rtl/sdw_ctrl.sv ***
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module sdw_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_buf_req,
    input wire logic tx_buf_req,
    output logic receive_dma_request,
    output logic transmit_dma_request,
    input wire logic [15:0] buf_rd_data,
    output logic buf_rd_strobe,
    output logic [15:0] buf_wr_data,
    output logic buf_wr_strobe,
    output logic timing_mode_select,
    output logic module_clk_en,
    output logic card_clock_loop_select,
    output logic wrapper_soft_reset,
    output logic core_reset_n,
    output logic [2:0] internal_adjust_field,
    output logic card_clock_out_pin,
    input wire logic card_dat1_in,
    input wire logic bus_4bit,
    input wire logic data_busy,
    input wire logic sync_window,
    output logic host_side_irq_out,
    output logic card_side_irq_out
);
    sdw_pkg::sdw_regs_s st;
    sdw_pkg::sdw_regs_s next_st;
    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic mapped;
    logic route_on;
    logic [31:0] rd_val;

    function automatic logic hit(input logic [31:0] a);
        hit = (a == sdw_pkg::ADDR_USER) || (a == sdw_pkg::ADDR_USER2) ||
              (a == sdw_pkg::ADDR_CORE_RST) || (a == sdw_pkg::ADDR_CLKDIV) ||
              (a == sdw_pkg::ADDR_SDIO) || (a == sdw_pkg::ADDR_DMABUF);
    endfunction

    // Read data is sampled in the setup cycle so prdata comes from a flop
    always_comb begin
        rd_val = 32'h0000_0000;
        case (paddr)
            sdw_pkg::ADDR_USER: begin
                rd_val[sdw_pkg::USER_SYNC_BIT] = st.sync;
                rd_val[sdw_pkg::USER_RDPEND_BIT] = st.rx_req;
                rd_val[sdw_pkg::USER_WRPEND_BIT] = st.tx_req;
                rd_val[sdw_pkg::USER_LOOP_BIT] = st.loop;
                rd_val[sdw_pkg::USER_GATE_BIT] = st.gate;
                rd_val[sdw_pkg::USER_ROUTE_LSB +: 3] = st.route;
                rd_val[sdw_pkg::USER_CD_BIT] = st.cd;
            end
            sdw_pkg::ADDR_USER2: begin
                rd_val[sdw_pkg::USER2_ADJ_LSB +: 3] = st.adj;
                rd_val[sdw_pkg::USER2_SMODE_BIT] = st.smode;
            end
            sdw_pkg::ADDR_CORE_RST: begin
                rd_val[2:1] = sdw_pkg::CORE_RST_FIXED;
                rd_val[0] = st.core_rst;
            end
            sdw_pkg::ADDR_CLKDIV: begin
                rd_val[1:0] = st.div;
            end
            sdw_pkg::ADDR_SDIO: begin
                rd_val[sdw_pkg::SDIO_HOST_BIT] = host_side_irq_out;
                rd_val[sdw_pkg::SDIO_CARD_BIT] = card_side_irq_out;
            end
            sdw_pkg::ADDR_DMABUF: begin
                rd_val[15:0] = buf_rd_data;
            end
            default: begin
                rd_val = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        setup = psel && !penable;
        access = psel && penable;
        mapped = hit(paddr);
        wr = access && pwrite && mapped;
        rd = access && !pwrite && mapped;
        route_on = (st.route == sdw_pkg::ROUTE_BOTH_A) ||
                   (st.route == sdw_pkg::ROUTE_BOTH_B);
        next_st = st;
        next_st.rd_stb = 1'b0;
        next_st.wr_stb = 1'b0;
        next_st.irq_clr = 1'b0;
        if (setup) begin
            next_st.rdata = pwrite ? 32'h0000_0000 : rd_val;
        end
        // Requests pass through only while routed and the wrapper is out of reset
        next_st.rx_req = rx_buf_req && route_on && !st.cd;
        next_st.tx_req = tx_buf_req && route_on && !st.cd;
        if (wr) begin
            case (paddr)
                sdw_pkg::ADDR_USER: begin
                    next_st.sync = pwdata[sdw_pkg::USER_SYNC_BIT];
                    next_st.loop = pwdata[sdw_pkg::USER_LOOP_BIT];
                    next_st.gate = pwdata[sdw_pkg::USER_GATE_BIT];
                    next_st.route = pwdata[sdw_pkg::USER_ROUTE_LSB +: 3];
                    next_st.cd = pwdata[sdw_pkg::USER_CD_BIT];
                end
                sdw_pkg::ADDR_USER2: begin
                    // Stored as written; other values are not meaningful
                    next_st.adj = pwdata[sdw_pkg::USER2_ADJ_LSB +: 3];
                    next_st.smode = pwdata[sdw_pkg::USER2_SMODE_BIT];
                end
                sdw_pkg::ADDR_CORE_RST: begin
                    next_st.core_rst = pwdata[0];
                end
                sdw_pkg::ADDR_CLKDIV: begin
                    next_st.div = pwdata[1:0];
                end
                sdw_pkg::ADDR_SDIO: begin
                    next_st.irq_clr = pwdata[sdw_pkg::SDIO_HOST_BIT];
                end
                sdw_pkg::ADDR_DMABUF: begin
                    // Meant for the DMA controller, not the processor
                    next_st.dmabuf = pwdata[15:0];
                    next_st.wr_stb = 1'b1;
                end
                default: begin
                    next_st.wr_stb = 1'b0;
                end
            endcase
        end
        if (rd && paddr == sdw_pkg::ADDR_DMABUF) begin
            next_st.rd_stb = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.route <= sdw_pkg::ROUTE_RESET;
            st.core_rst <= sdw_pkg::CORE_RST_RESET;
            st.div <= sdw_pkg::CLKDIV_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.rdata;
    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign receive_dma_request = st.rx_req;
    assign transmit_dma_request = st.tx_req;
    assign buf_rd_strobe = st.rd_stb;
    assign buf_wr_data = st.dmabuf;
    assign buf_wr_strobe = st.wr_stb;
    assign timing_mode_select = st.sync | st.smode;
    assign module_clk_en = ~st.gate;
    assign card_clock_loop_select = st.loop;
    assign wrapper_soft_reset = st.cd;
    assign core_reset_n = st.core_rst;
    assign internal_adjust_field = st.adj;

    sdw_clkdiv u_div (
        .pclk(pclk),
        .presetn(presetn),
        .en(module_clk_en),
        .div_sel(st.div),
        .card_clk(card_clock_out_pin)
    );

    sdw_irq_det u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .soft_rst(st.cd),
        .dat1_pin(card_dat1_in),
        .bus_4bit(bus_4bit),
        .data_busy(data_busy),
        .sync_window(sync_window),
        .clear(st.irq_clr),
        .host_irq(host_side_irq_out),
        .card_irq(card_side_irq_out)
    );

    property p_mode;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == sdw_pkg::ADDR_USER2 && pwdata[0]) |=> timing_mode_select;
    endproperty
    a_mode: assert property (p_mode) else $error("sync mode bit not effective");
    property p_mode_off;
        @(posedge pclk) disable iff (!presetn)
        (!st.sync && !st.smode) |-> !timing_mode_select;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("mode high with both bits low");
    property p_pend_read;
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == sdw_pkg::ADDR_USER)
            |=> prdata[14] == $past(receive_dma_request) &&
                prdata[13] == $past(transmit_dma_request);
    endproperty
    a_pend_read: assert property (p_pend_read) else $error("pending bits misread");
    property p_gate;
        @(posedge pclk) disable iff (!presetn)
        !module_clk_en ##1 !module_clk_en |-> $stable(card_clock_out_pin);
    endproperty
    a_gate: assert property (p_gate) else $error("card clock ran while stopped");
    property p_route_none;
        @(posedge pclk) disable iff (!presetn)
        (st.route == sdw_pkg::ROUTE_NONE) |=> !receive_dma_request && !transmit_dma_request;
    endproperty
    a_route_none: assert property (p_route_none) else $error("request with route 010");
    property p_route_rx;
        @(posedge pclk) disable iff (!presetn)
        (rx_buf_req && route_on && !st.cd) |=> receive_dma_request;
    endproperty
    a_route_rx: assert property (p_route_rx) else $error("routed rx request lost");
    property p_cd;
        @(posedge pclk) disable iff (!presetn)
        wrapper_soft_reset |=> !receive_dma_request && !transmit_dma_request;
    endproperty
    a_cd: assert property (p_cd) else $error("request during wrapper reset");
    property p_core;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == sdw_pkg::ADDR_CORE_RST) |=> core_reset_n == $past(pwdata[0]);
    endproperty
    a_core: assert property (p_core) else $error("core reset bit not applied");
    property p_dmabuf;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == sdw_pkg::ADDR_DMABUF)
            |=> buf_wr_strobe && buf_wr_data == $past(pwdata[15:0]) ##1 !buf_wr_strobe;
    endproperty
    a_dmabuf: assert property (p_dmabuf) else $error("dma buffer write wrong");

    c_dma_wr: cover property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == sdw_pkg::ADDR_DMABUF);
    c_rx_req: cover property (@(posedge pclk) disable iff (!presetn)
        rx_buf_req ##1 receive_dma_request);
    c_gate: cover property (@(posedge pclk) disable iff (!presetn)
        module_clk_en ##1 !module_clk_en);
endmodule
`default_nettype wire

// *** tb/sdw_card_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdw_card_model (
    input wire logic pclk,
    input wire logic irq_low,
    input wire logic xfer,
    output logic dat1
);
    logic pat = 1'b0;
    always @(posedge pclk) begin
        pat <= ~pat;
    end
    // Block data toggles the line; otherwise the pull-up wins unless the card signals
    always_comb begin
        if (xfer) begin
            dat1 = pat;
        end else begin
            dat1 = ~irq_low;
        end
    end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic rx_req = 1'b0, tx_req = 1'b0, rx_out, tx_out;
    logic [15:0] rd_data = 16'h3C5A, wr_data;
    logic rd_stb, wr_stb, tmode, clk_en, loop_sel, wsr, core_n, card_clk, host_irq, card_irq;
    logic [2:0] adj;
    logic dat1, irq_low = 1'b0, xfer = 1'b0, b4 = 1'b0, busy = 1'b0, swin = 1'b0;
    int n_fail = 0;
    int n_tests = 0;
    always #4 pclk = ~pclk;
    sdw_card_model card (.pclk(pclk), .irq_low(irq_low), .xfer(xfer), .dat1(dat1));
    sdw_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_buf_req(rx_req), .tx_buf_req(tx_req),
        .receive_dma_request(rx_out), .transmit_dma_request(tx_out),
        .buf_rd_data(rd_data), .buf_rd_strobe(rd_stb), .buf_wr_data(wr_data),
        .buf_wr_strobe(wr_stb), .timing_mode_select(tmode), .module_clk_en(clk_en),
        .card_clock_loop_select(loop_sel), .wrapper_soft_reset(wsr), .core_reset_n(core_n),
        .internal_adjust_field(adj), .card_clock_out_pin(card_clk), .card_dat1_in(dat1),
        .bus_4bit(b4), .data_busy(busy), .sync_window(swin),
        .host_side_irq_out(host_irq), .card_side_irq_out(card_irq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        err = pslverr;
        if (n >= 50) chk(1'b0, 1'b1, "pready timeout");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp, msg);
        chk(e, 1'b0, "unexpected slave error");
    endtask
    task automatic t_reset();
        rd(sdw_pkg::ADDR_USER, 32'h0000_0004, "control reset");
        rd(sdw_pkg::ADDR_USER2, 32'h0, "sync control reset");
        rd(sdw_pkg::ADDR_DMABUF, 32'h0000_3C5A, "buffer port read");
        chk(wr_data, 16'h0, "buffer port reset");
        rd(sdw_pkg::ADDR_CORE_RST, 32'h0000_0007, "core reset reg");
        chk({clk_en, core_n, wsr, tmode}, 4'hC, "reset outputs");
    endtask
    task automatic t_sync();
        for (int p = 0; p < 4; p++) begin
            wr(sdw_pkg::ADDR_USER, 32'h4 | (32'(p[1]) << 15));
            wr(sdw_pkg::ADDR_USER2, 32'(p[0]));
            settle(1);
            chk(tmode, p[1] | p[0], "timing mode");
            chk(adj, 3'h0, "adjust field");
        end
        wr(sdw_pkg::ADDR_USER2, 32'h0);
    endtask
    task automatic t_gate();
        logic c;
        wr(sdw_pkg::ADDR_USER, 32'h0000_0184);
        settle(1);
        chk(clk_en, 1'b0, "clock stop");
        chk(loop_sel, 1'b1, "loop select");
        c = card_clk;
        settle(20);
        chk(card_clk, c, "card clock frozen");
        wr(sdw_pkg::ADDR_USER, 32'h0000_0004);
        settle(1);
        chk(clk_en, 1'b1, "clock run");
    endtask
    task automatic t_route();
        logic [31:0] q;
        logic e;
        rx_req <= 1'b1;
        tx_req <= 1'b1;
        for (int c = 0; c < 3; c++) begin
            wr(sdw_pkg::ADDR_USER, 32'h6000 | (32'(c) << 2));
            settle(2);
            chk({rx_out, tx_out}, (c < 2) ? 2'h3 : 2'h0, "dma routing");
            rd(sdw_pkg::ADDR_USER, (32'(c) << 2) | ((c < 2) ? 32'h6000 : 32'h0), "pending");
        end
        wr(sdw_pkg::ADDR_USER, 32'h0000_0005);
        settle(2);
        chk({wsr, rx_out, tx_out}, 3'h4, "soft reset");
        wr(sdw_pkg::ADDR_USER, 32'h0000_0004);
        settle(2);
        chk({wsr, rx_out, tx_out}, 3'h3, "soft reset released");
        rx_req <= 1'b0;
        tx_req <= 1'b0;
        settle(2);
        chk({rx_out, tx_out}, 2'h0, "requests drop");
        apb(1'b0, 32'h5005_0210, 32'h0, q, e);
        chk(32'(e), 32'h1, "unmapped slave error");
        chk(q, 32'h0, "unmapped read data");
    endtask
    task automatic t_core_buf();
        wr(sdw_pkg::ADDR_CORE_RST, 32'h6);
        settle(1);
        chk(core_n, 1'b0, "core held");
        wr(sdw_pkg::ADDR_CORE_RST, 32'h7);
        settle(1);
        chk(core_n, 1'b1, "core released");
        wr(sdw_pkg::ADDR_DMABUF, 32'h0000_A5C3);
        #1;
        chk(wr_stb, 1'b1, "write strobe");
        chk(wr_data, 16'hA5C3, "buffer write data");
        settle(1);
        chk(wr_stb, 1'b0, "write strobe width");
        rd(sdw_pkg::ADDR_DMABUF, 32'h0000_3C5A, "buffer read");
        #1;
        chk(rd_stb, 1'b1, "read strobe");
    endtask
    task automatic t_clkdiv();
        int c;
        logic last;
        for (int dv = 0; dv < 4; dv++) begin
            wr(sdw_pkg::ADDR_CLKDIV, 32'(dv));
            settle(2);
            for (int k = 0; k < 2; k++) begin
                last = card_clk;
                c = 0;
                while (card_clk === last && c < 40) begin
                    settle(1);
                    c++;
                end
            end
            chk(32'(c), 32'(1 << dv), "card clock half period");
        end
    endtask
    task automatic t_irq();
        busy <= 1'b1;
        irq_low <= 1'b1;
        settle(4);
        chk({host_irq, card_irq}, 2'h3, "1-bit irq during data");
        irq_low <= 1'b0;
        settle(4);
        chk({host_irq, card_irq}, 2'h2, "host latched, card follows");
        wr(sdw_pkg::ADDR_SDIO, 32'h1);
        settle(2);
        chk(host_irq, 1'b0, "host cleared");
        b4 <= 1'b1;
        xfer <= 1'b1;
        settle(12);
        chk({host_irq, card_irq}, 2'h0, "4-bit block ignored");
        xfer <= 1'b0;
        busy <= 1'b0;
        irq_low <= 1'b1;
        settle(4);
        chk({host_irq, card_irq}, 2'h3, "4-bit idle irq");
        rd(sdw_pkg::ADDR_SDIO, 32'h0000_0003, "irq status read");
        irq_low <= 1'b0;
        wr(sdw_pkg::ADDR_SDIO, 32'h1);
        busy <= 1'b1;
        swin <= 1'b1;
        settle(3);
        irq_low <= 1'b1;
        settle(4);
        chk({host_irq, card_irq}, 2'h2, "sync window irq");
        irq_low <= 1'b0;
        wr(sdw_pkg::ADDR_USER, 32'h0000_0005);
        settle(2);
        chk(host_irq, 1'b0, "soft reset clears latch");
        wr(sdw_pkg::ADDR_USER, 32'h0000_0004);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_sync();
        t_gate();
        t_route();
        t_core_buf();
        t_clkdiv();
        t_irq();
        conclude();
    end
endmodule
`default_nettype wire
